// file: rtl/pclkc_top.sv
// decode of the analog and timing control register into clock path controls
//
// Functional notes
// (R1) rising surge bits 31:29 add 7.6, 3.8, 1.9 mA independently
// (R2) falling surge bits 28:26 add 5.4, 2.7, 1.35 mA independently
// (R3) bit 25 set drives shared lock pin as lock detect output
// (R4) bit 24 clear: indicator 0 when locked, 1 when unlocked
// (R5) bit 24 set: indicator 1 when feedback lags, 0 when it leads
// (R6) bit 23 set stops rf divider, routes rf input to system clock
// (R7) bits 22:21 divide rf input by 1,2,4,8; 00 is divide by one
// (R8) bit 20 resets to 1 keeping driver off; 0 powers it up
// (R9) bits 19:18 pick driver source: off, feedback, divider out, divider in
// (R10) bit 17 set removes all surge current including the defaults
// (R11) bit 16 picks divider output (0) or divider input (1) as system clock
// (R12) reference divide N equals bits 15:12 plus one
// (R13) feedback divide M equals bits 11:8 plus one
// (R14) host writes zeros to bits 7:6
// (R15) bit 5 inverts charge pump up and down directions
// (R16) bit 4 fully powers down the charge pump
// (R17) bit 3 disables only the pump output buffer
// (R18) pump current scale equals bits 2:0 plus one
// (R19) host always writes all five bytes together
// (R20) outputs reset to defaults and change only after a whole write; lock pin and pump up/down outputs also follow loop status
`timescale 1ns/1ns
module pclkc_top
    import pclkc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic WRITE_STROBE,
    input wire logic [39:0] WRITE_DATA,
    input wire logic PLL_LOCKED,
    input wire logic FEEDBACK_LAGS,
    input wire logic FEEDBACK_LEADS,
    output logic [39:0] READ_DATA,
    output logic LOCK_PIN_OUT,
    output logic LOCK_PIN_OE_N,
    output logic RF_DIV_RUN,
    output logic RF_BYPASS_PATH_EN,
    output logic [3:0] RF_DIV_RATIO,
    output logic DRIVER_POWER_ON,
    output logic [1:0] DRIVER_SOURCE,
    output logic DRIVER_TOGGLE_EN,
    output logic [8:0] RISE_SURGE,
    output logic [8:0] FALL_SURGE,
    output logic DDS_SYSTEM_CLOCK_FROM_DIV_INPUT,
    output logic [4:0] REF_DIV_N,
    output logic [4:0] FB_DIV_M,
    output logic PUMP_UP,
    output logic PUMP_DOWN,
    output logic PUMP_CORE_ON,
    output logic PUMP_OUTPUT_ON,
    output logic [3:0] PUMP_SCALE
);
    // ****************************************
    // input synchronisers for detector status
    // ****************************************
    logic [2:0] stat_meta;
    logic [2:0] stat_sync;
    // status lines come from the analog detector, another timing domain
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            stat_meta <= 3'h0;
            stat_sync <= 3'h0;
        end else begin
            stat_meta <= {PLL_LOCKED, FEEDBACK_LAGS, FEEDBACK_LEADS};
            stat_sync <= stat_meta;
        end
    end
    logic locked_s;
    logic lags_s;
    logic leads_s;
    assign locked_s = stat_sync[2];
    assign lags_s = stat_sync[1];
    assign leads_s = stat_sync[0];

    // ****************************************
    // register image
    // ****************************************
    logic [39:0] atc;
    // (R20) whole word commit
    // the serial port hands over all five bytes at once, so no partial state exists
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            atc <= ATC_RESET;
        end else if (WRITE_STROBE) begin
            atc <= WRITE_DATA;
        end
    end

    // ****************************************
    // decode helpers
    // ****************************************
    // (R7) ratio decode
    function automatic logic [3:0] rf_ratio(input logic [1:0] code);
        logic [3:0] r;
        r = 4'h1 << code;
        return r;
    endfunction

    // (R12) plus one divide
    function automatic logic [4:0] plus_one(input logic [3:0] f);
        return {1'b0, f} + 5'h01;
    endfunction

    logic [8:0] next_rise;
    logic [8:0] next_fall;
    // (R1) rising surge sum
    pclkc_surge #(.W(9)) u_rise (
        .enables(atc[F_RISE_HI:F_RISE_LO]),
        .base(RISE_BASE),
        .w2(RISE_W2),
        .w1(RISE_W1),
        .w0(RISE_W0),
        .slew_off(atc[F_SLEW_OFF]),
        .total(next_rise)
    );
    // (R2) falling surge sum
    pclkc_surge #(.W(9)) u_fall (
        .enables(atc[F_FALL_HI:F_FALL_LO]),
        .base(FALL_BASE),
        .w2(FALL_W2),
        .w1(FALL_W1),
        .w0(FALL_W0),
        .slew_off(atc[F_SLEW_OFF]),
        .total(next_fall)
    );

    // ****************************************
    // lock pin
    // ****************************************
    logic next_lock_val;
    always_comb begin
        // (R5) lead lag mode
        if (atc[F_LOCK_MODE]) begin
            next_lock_val = lags_s & ~leads_s;
        end else begin
            // (R4) status mode, low means locked
            next_lock_val = ~locked_s;
        end
    end
    // (R3) pin drive enable
    // oe is active low; the pin floats while the function is off
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            LOCK_PIN_OUT <= 1'b0;
            LOCK_PIN_OE_N <= 1'b1;
        end else begin
            LOCK_PIN_OUT <= atc[F_LOCK_EN] ? next_lock_val : 1'b0;
            LOCK_PIN_OE_N <= ~atc[F_LOCK_EN];
        end
    end

    // ****************************************
    // rf divider and system clock path
    // ****************************************
    // (R6) divider stop and bypass
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            RF_DIV_RUN <= 1'b1;
            RF_BYPASS_PATH_EN <= 1'b0;
            RF_DIV_RATIO <= 4'h8;
            DDS_SYSTEM_CLOCK_FROM_DIV_INPUT <= 1'b0;
        end else begin
            RF_DIV_RUN <= ~atc[F_RFDIV_PD];
            RF_BYPASS_PATH_EN <= atc[F_RFDIV_PD];
            // (R7) divide ratio
            RF_DIV_RATIO <= rf_ratio(atc[F_RFDIV_HI:F_RFDIV_LO]);
            // (R11) system clock mux
            DDS_SYSTEM_CLOCK_FROM_DIV_INPUT <= atc[F_DDS_SYSTEM_CLOCK_MUX];
        end
    end

    // ****************************************
    // clock driver
    // ****************************************
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            DRIVER_POWER_ON <= 1'b0;
            DRIVER_SOURCE <= DRV_SRC_DIV_OUT;
            DRIVER_TOGGLE_EN <= 1'b0;
            RISE_SURGE <= RISE_BASE;
            FALL_SURGE <= FALL_BASE;
        end else begin
            // (R8) driver power, off at reset
            DRIVER_POWER_ON <= ~atc[F_DRV_PD];
            // (R9) source select; off source never toggles
            DRIVER_SOURCE <= atc[F_DRV_SEL_HI:F_DRV_SEL_LO];
            DRIVER_TOGGLE_EN <= ~atc[F_DRV_PD] && (atc[F_DRV_SEL_HI:F_DRV_SEL_LO] != DRV_SRC_OFF);
            // (R10) slew suppression applied inside the sums
            RISE_SURGE <= next_rise;
            FALL_SURGE <= next_fall;
        end
    end

    // ****************************************
    // loop dividers
    // ****************************************
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            REF_DIV_N <= 5'h01;
            FB_DIV_M <= 5'h01;
        end else begin
            // (R12) reference divider
            REF_DIV_N <= plus_one(atc[F_NDIV_HI:F_NDIV_LO]);
            // (R13) feedback divider
            FB_DIV_M <= plus_one(atc[F_MDIV_HI:F_MDIV_LO]);
        end
    end

    // ****************************************
    // charge pump
    // ****************************************
    logic raw_up;
    logic raw_down;
    logic pump_out_en;
    // (R15) polarity swap of pump direction
    assign raw_up = atc[F_CP_POL] ? leads_s : lags_s;
    assign raw_down = atc[F_CP_POL] ? lags_s : leads_s;
    // (R16) full power down gates everything
    // (R17) quick power down gates only the output
    assign pump_out_en = ~atc[F_CP_FULL_PD] & ~atc[F_CP_QUICK_PD];
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            PUMP_UP <= 1'b0;
            PUMP_DOWN <= 1'b0;
            PUMP_CORE_ON <= 1'b1;
            PUMP_OUTPUT_ON <= 1'b1;
            PUMP_SCALE <= 4'h1;
        end else begin
            PUMP_UP <= pump_out_en & raw_up & ~raw_down;
            PUMP_DOWN <= pump_out_en & raw_down & ~raw_up;
            PUMP_CORE_ON <= ~atc[F_CP_FULL_PD];
            PUMP_OUTPUT_ON <= pump_out_en;
            // (R18) current scale
            PUMP_SCALE <= {1'b0, atc[F_CP_SCALE_HI:F_CP_SCALE_LO]} + 4'h1;
        end
    end

    // ****************************************
    // read back
    // ****************************************
    // open bits read as written; the host is expected to keep them zero
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            READ_DATA <= ATC_RESET;
        end else begin
            READ_DATA <= atc;
        end
    end
endmodule

// file: rtl/pclkc_pkg.sv
// shared constants for the analog and timing control decode block
package pclkc_pkg;
    // ****************************************
    // register geometry
    // ****************************************
    localparam int ATC_WIDTH = 40;
    localparam int ATC_BYTES = 5;
    // divide by 8, driver powered down, source divider out, all else clear
    localparam logic [39:0] ATC_RESET = 40'h00_0078_0000;
    // ****************************************
    // field positions
    // ****************************************
    localparam int F_RISE_HI = 31;
    localparam int F_RISE_LO = 29;
    localparam int F_FALL_HI = 28;
    localparam int F_FALL_LO = 26;
    localparam int F_LOCK_EN = 25;
    localparam int F_LOCK_MODE = 24;
    localparam int F_RFDIV_PD = 23;
    localparam int F_RFDIV_HI = 22;
    localparam int F_RFDIV_LO = 21;
    localparam int F_DRV_PD = 20;
    localparam int F_DRV_SEL_HI = 19;
    localparam int F_DRV_SEL_LO = 18;
    localparam int F_SLEW_OFF = 17;
    localparam int F_DDS_SYSTEM_CLOCK_MUX = 16;
    localparam int F_NDIV_HI = 15;
    localparam int F_NDIV_LO = 12;
    localparam int F_MDIV_HI = 11;
    localparam int F_MDIV_LO = 8;
    localparam int F_CP_POL = 5;
    localparam int F_CP_FULL_PD = 4;
    localparam int F_CP_QUICK_PD = 3;
    localparam int F_CP_SCALE_HI = 2;
    localparam int F_CP_SCALE_LO = 0;
    // ****************************************
    // encodings
    // ****************************************
    localparam logic [1:0] DRV_SRC_OFF = 2'h0;
    localparam logic [1:0] DRV_SRC_FEEDBACK = 2'h1;
    localparam logic [1:0] DRV_SRC_DIV_OUT = 2'h2;
    localparam logic [1:0] DRV_SRC_DIV_IN = 2'h3;
    // surge current weights in units of 0.05 mA; nine bits since full sums pass 255
    localparam logic [8:0] RISE_W2 = 9'h098;  // 7.6 mA
    localparam logic [8:0] RISE_W1 = 9'h04c;  // 3.8 mA
    localparam logic [8:0] RISE_W0 = 9'h026;  // 1.9 mA
    localparam logic [8:0] FALL_W2 = 9'h06c;  // 5.4 mA
    localparam logic [8:0] FALL_W1 = 9'h036;  // 2.7 mA
    localparam logic [8:0] FALL_W0 = 9'h01b;  // 1.35 mA
    localparam logic [8:0] RISE_BASE = 9'h098; // 7.6 mA
    localparam logic [8:0] FALL_BASE = 9'h051; // 4.05 mA
endpackage

// file: rtl/pclkc_surge.sv
// edge surge current sum for one edge of the clock driver
`timescale 1ns/1ns
module pclkc_surge
    import pclkc_pkg::*;
#(
    parameter int W = 9
) (
    input wire logic [2:0] enables,
    input wire logic [W-1:0] base,
    input wire logic [W-1:0] w2,
    input wire logic [W-1:0] w1,
    input wire logic [W-1:0] w0,
    input wire logic slew_off,
    output logic [W-1:0] total
);
    // the largest sum is 20.9 mA, which needs nine bits of 0.05 mA
    if (W < 9) begin : g_width_check
        $error("surge width too small");
    end
    // each bit adds its own weight independently; slew_off kills everything
    always_comb begin
        total = base;
        if (enables[2]) total = W'(total + w2);
        if (enables[1]) total = W'(total + w1);
        if (enables[0]) total = W'(total + w0);
        if (slew_off) total = '0;
    end
endmodule

// file: verification/pclkc_monitor.sv
// concurrent checks on the control register decode ports
`timescale 1ns/1ns
module pclkc_monitor (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic WRITE_STROBE,
    input wire logic [39:0] WRITE_DATA,
    input wire logic PLL_LOCKED,
    input wire logic [39:0] READ_DATA,
    input wire logic LOCK_PIN_OUT,
    input wire logic LOCK_PIN_OE_N,
    input wire logic [3:0] RF_DIV_RATIO,
    input wire logic [1:0] DRIVER_SOURCE,
    input wire logic DRIVER_POWER_ON,
    input wire logic DRIVER_TOGGLE_EN,
    input wire logic [8:0] RISE_SURGE,
    input wire logic [8:0] FALL_SURGE,
    input wire logic [4:0] REF_DIV_N,
    input wire logic [4:0] FB_DIV_M,
    input wire logic PUMP_CORE_ON,
    input wire logic PUMP_OUTPUT_ON
);
    // ****************************************
    // port checks
    // ****************************************
    // outputs trail the stored word by one edge, so decode is judged against the read-back copy
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    write_takes_a: assert property (WRITE_STROBE |-> ##2 READ_DATA == $past(WRITE_DATA, 2))
        else $error("register word not shown two edges after strobe");
    hold_value_a: assert property ($changed(READ_DATA) |-> $past(WRITE_STROBE, 2))
        else $error("register word changed without a write");
    ratio_decode_a: assert property ($past(RESETN) |-> RF_DIV_RATIO == 4'h1 << READ_DATA[22:21])
        else $error("rf divider ratio wrong");
    driver_decode_a: assert property (DRIVER_SOURCE == READ_DATA[19:18] && DRIVER_POWER_ON == !READ_DATA[20]
        && DRIVER_TOGGLE_EN == (!READ_DATA[20] && READ_DATA[19:18] != 2'h0)) else $error("driver decode wrong");
    divider_decode_a: assert property (REF_DIV_N == READ_DATA[15:12] + 5'h1 && FB_DIV_M == READ_DATA[11:8] + 5'h1)
        else $error("loop divider ratio wrong");
    pump_power_a: assert property (PUMP_CORE_ON == !READ_DATA[4] && PUMP_OUTPUT_ON == !(READ_DATA[4] || READ_DATA[3]))
        else $error("pump power state wrong");
    lock_enable_a: assert property (!READ_DATA[25] |-> LOCK_PIN_OE_N && !LOCK_PIN_OUT)
        else $error("lock pin driven while disabled");
    lock_status_a: assert property ((READ_DATA[25:24] == 2'h2 && $stable(PLL_LOCKED))[*4]
        |-> LOCK_PIN_OUT == !PLL_LOCKED) else $error("lock status level wrong");
    surge_off_a: assert property (READ_DATA[17] |-> RISE_SURGE == 9'h0 && FALL_SURGE == 9'h0)
        else $error("surge current present with slew off");
endmodule
bind pclkc_top pclkc_monitor pclkc_monitor_inst (.CLOCK(CLOCK), .RESETN(RESETN), .WRITE_STROBE(WRITE_STROBE),
    .WRITE_DATA(WRITE_DATA), .PLL_LOCKED(PLL_LOCKED), .READ_DATA(READ_DATA), .LOCK_PIN_OUT(LOCK_PIN_OUT),
    .LOCK_PIN_OE_N(LOCK_PIN_OE_N), .RF_DIV_RATIO(RF_DIV_RATIO), .DRIVER_SOURCE(DRIVER_SOURCE),
    .DRIVER_POWER_ON(DRIVER_POWER_ON), .DRIVER_TOGGLE_EN(DRIVER_TOGGLE_EN), .RISE_SURGE(RISE_SURGE),
    .FALL_SURGE(FALL_SURGE), .REF_DIV_N(REF_DIV_N), .FB_DIV_M(FB_DIV_M), .PUMP_CORE_ON(PUMP_CORE_ON),
    .PUMP_OUTPUT_ON(PUMP_OUTPUT_ON));

// file: verification/pclkc_partner.sv
// serial host and loop status model feeding the decode block
`timescale 1ns/1ns
module pclkc_partner (
    input wire logic clock,
    output logic strobe,
    output logic [39:0] data,
    output logic locked,
    output logic lags,
    output logic leads
);
    // ****************************************
    // host and loop
    // ****************************************
    // idle data shows the inverse of the last word so a stale copy is never mistaken for a write
    initial begin
        strobe = 1'b0;
        data = 40'h0;
        {locked, lags, leads} = 3'h0;
    end
    task automatic put(input logic [39:0] w, input bit last);
        strobe = 1'b1;
        data = w & ~40'hc0;
        @(negedge clock);
        if (last) begin
            strobe = 1'b0;
            data = ~data;
        end
    endtask
    task automatic loop_state(input logic [2:0] s);
        {locked, lags, leads} = s;
    endtask
endmodule

// file: verification/testbench.sv
// self-checking bench for the control register decode block
`timescale 1ns/1ns
module testbench;
    import pclkc_pkg::*;
    // ****************************************
    // harness
    // ****************************************
    logic clock, resetn, strobe, locked, lags, leads;
    logic [39:0] wdata, rd;
    logic pin, oe_n, run, byp, pwr, tog, mux, up, dn, core, oon;
    logic [3:0] ratio, scale;
    logic [1:0] src;
    logic [8:0] rise, fall;
    logic [4:0] n, m;
    int err_count = 0;
    int checked = 0;
    // every word is preceded by its inverse on the edge before, so each entry is a back-to-back pair
    logic [39:0] words [5] = '{40'h00_5e05_f007, 40'h81_23bc_0f20, 40'h00_8242_7813, 40'h00_0368_120d,
        40'h00_0000_0002};
    logic [2:0] loops [5] = '{3'h4, 3'h2, 3'h0, 3'h1, 3'h6};
    pclkc_partner pclkc_partner_inst (.clock(clock), .strobe(strobe), .data(wdata), .locked(locked),
        .lags(lags), .leads(leads));
    pclkc_top pclkc_top_inst (.CLOCK(clock), .RESETN(resetn), .WRITE_STROBE(strobe), .WRITE_DATA(wdata),
        .PLL_LOCKED(locked), .FEEDBACK_LAGS(lags), .FEEDBACK_LEADS(leads), .READ_DATA(rd), .LOCK_PIN_OUT(pin),
        .LOCK_PIN_OE_N(oe_n), .RF_DIV_RUN(run), .RF_BYPASS_PATH_EN(byp), .RF_DIV_RATIO(ratio),
        .DRIVER_POWER_ON(pwr), .DRIVER_SOURCE(src), .DRIVER_TOGGLE_EN(tog), .RISE_SURGE(rise),
        .FALL_SURGE(fall), .DDS_SYSTEM_CLOCK_FROM_DIV_INPUT(mux), .REF_DIV_N(n), .FB_DIV_M(m), .PUMP_UP(up),
        .PUMP_DOWN(dn), .PUMP_CORE_ON(core), .PUMP_OUTPUT_ON(oon), .PUMP_SCALE(scale));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // ****************************************
    // checking
    // ****************************************
    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // s holds locked, lags, leads from the top bit down
    task automatic verify(input logic [39:0] w, input logic [2:0] s);
        logic [39:0] r;
        logic [39:0] f;
        r = w[17] ? 40'h0 : RISE_BASE + (w[31] ? RISE_W2 : 8'h0) + (w[30] ? RISE_W1 : 8'h0) + (w[29] ? RISE_W0 : 8'h0);
        f = w[17] ? 40'h0 : FALL_BASE + (w[28] ? FALL_W2 : 8'h0) + (w[27] ? FALL_W1 : 8'h0) + (w[26] ? FALL_W0 : 8'h0);
        check("read back", rd, w);
        check("rf divider", {run, byp, ratio}, {~w[23], w[23], 4'h1 << w[22:21]});
        check("driver", {pwr, src, tog}, {~w[20], w[19:18], ~w[20] && (w[19:18] != 2'h0)});
        check("rise surge", rise, r);
        check("fall surge", fall, f);
        check("dds_system_clock mux", mux, w[16]);
        check("ref divider", n, w[15:12] + 5'h1);
        check("fb divider", m, w[11:8] + 5'h1);
        check("pump power", {core, oon}, {~w[4], ~(w[4] | w[3])});
        check("pump scale", scale, w[2:0] + 4'h1);
        check("pump dir", {up, dn}, (w[4] | w[3]) ? 2'h0 : (w[5] ? {s[0], s[1]} : s[1:0]));
        check("lock pin", {oe_n, pin}, {~w[25], w[25] & (w[24] ? s[1] & ~s[0] : ~s[2])});
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        resetn = 1'b0;
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
        verify(ATC_RESET, 3'h0);
        $display("reset defaults test done");
        foreach (words[i]) begin
            pclkc_partner_inst.loop_state(loops[i]);
            pclkc_partner_inst.put(~words[i], 1'b0);
            pclkc_partner_inst.put(words[i], 1'b1);
            repeat (4) @(negedge clock);
            verify(words[i], loops[i]);
            $display("write pair test %0d done", i);
        end
        wrap_up();
    end
    // the tests need under a hundred cycles, so this only trips on a hang
    initial begin
        repeat (2000) @(posedge clock);
        err_count++;
        wrap_up();
    end
endmodule
